// File: rsc_params.svh
// Constants of the reset source control block: offsets, codes, reset values and timing.
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RSC_OFS_THRESH 4'h0
`define RSC_OFS_CAUSE 4'h4
`define RSC_OFS_CTRL 4'h8
`define RSC_OFS_STATUS 4'hc
// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define RSC_THR_2V10 8'h55
`define RSC_THR_2V55 8'h33
`define RSC_THR_3V15 8'h99
`define RSC_THR_3V80 8'haa
`define RSC_THR_POR 8'h55
`define RSC_WDK_ENABLE 5'h0a
`define RSC_WDK_DISABLE 5'h15
`define RSC_WDK_POR 5'h0a
`define RSC_BIT_SUPPLY 2
`define RSC_BIT_SELECT 1
`define RSC_BIT_WDKEY 0
// ----------------------------------------------------------------
// Timing in nanoseconds and clock period
// ----------------------------------------------------------------
`define RSC_CLK_NS 8
`define RSC_QUALIFY_NS 120000
`define RSC_FAULT_NS 100000
`define RSC_STARTUP_NS 1000000
`endif

// File: rsc_pkg.sv
// Types shared by the reset source control block.
package rsc_pkg;
  typedef struct packed {
    logic pin;
    logic supply;
    logic select;
    logic wdkey;
    logic wdt_normal;
    logic wdt_sleep;
  } rsc_cause_t;
  typedef enum logic [2:0] {
    RSC_RUN = 3'b001,
    RSC_HOLD = 3'b010,
    RSC_START = 3'b100
  } rsc_state_t;
endpackage

// File: rsc_reset_source_control.sv
// Reset source control: merges reset causes, keeps cause flags, drives core resets.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ns
`include "rsc_params.svh"
module rsc_reset_source_control #(
  parameter int QUALIFY_CYC = (`RSC_QUALIFY_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS,
  parameter int FAULT_CYC = (`RSC_FAULT_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS,
  parameter int STARTUP_CYC = (`RSC_STARTUP_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS
) (
  // Clock and power-on reset
  input wire logic core_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Asynchronous inputs from pins and analog
  input wire logic external_rst_pin_n,
  input wire logic low_supply_monitor,
  // Core status inputs
  input wire logic powerdown_mode,
  input wire logic sleep_idle_mode,
  input wire logic watchdog_timeout,
  // Reset, watchdog, flag and interrupt outputs to the core
  output logic core_full_rst,
  output logic core_pc_sp_rst,
  output logic por_defaults,
  output logic watchdog_enable,
  output logic watchdog_clear,
  output logic watchdog_expiry_flag,
  output logic powerdown_flag,
  output logic irq
);
  localparam int QW = $clog2(QUALIFY_CYC + 1);
  localparam int FW = $clog2(FAULT_CYC + 1);
  localparam int SW = $clog2(STARTUP_CYC + 1);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Pins are asynchronous; the first stage is read by the second only.
  logic [1:0] pin_sync;
  logic [1:0] sup_sync;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_sync <= 2'h3;
      sup_sync <= 2'h0;
    end else begin
      pin_sync <= {pin_sync[0], external_rst_pin_n};
      sup_sync <= {sup_sync[0], low_supply_monitor};
    end
  end
  wire pin_low = ~pin_sync[1];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] threshold_code;
  logic [4:0] watchdog_enable_key;
  logic [2:0] cause;
  logic [2:0] irq_mask;
  logic [QW-1:0] qual_cnt;
  logic [FW-1:0] fault_cnt;
  logic [SW-1:0] start_cnt;
  logic fault_select;
  logic fault_wdkey;
  rsc_pkg::rsc_state_t state;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire sel_thr = wb_adr_i == `RSC_OFS_THRESH;
  wire sel_cause = wb_adr_i == `RSC_OFS_CAUSE;
  wire sel_ctrl = wb_adr_i == `RSC_OFS_CTRL;
  wire sel_stat = wb_adr_i == `RSC_OFS_STATUS;
  wire thr_valid = (threshold_code == `RSC_THR_2V10) | (threshold_code == `RSC_THR_2V55) |
                   (threshold_code == `RSC_THR_3V15) | (threshold_code == `RSC_THR_3V80);
  wire key_valid = (watchdog_enable_key == `RSC_WDK_ENABLE) | (watchdog_enable_key == `RSC_WDK_DISABLE);
  // The monitor is ignored in power-down so a sagging idle supply cannot reset.
  wire sup_low = sup_sync[1] & ~powerdown_mode;
  wire supply_qualified = sup_low & (qual_cnt == QW'(QUALIFY_CYC));
  wire select_fire = fault_select & (fault_cnt == FW'(FAULT_CYC));
  wire wdkey_fire = fault_wdkey & (fault_cnt == FW'(FAULT_CYC));
  wire wdt_normal = watchdog_timeout & ~sleep_idle_mode & (state == rsc_pkg::RSC_RUN);
  wire wdt_sleep = watchdog_timeout & sleep_idle_mode & (state == rsc_pkg::RSC_RUN);
  rsc_pkg::rsc_cause_t ev;
  assign ev = '{pin: pin_low, supply: supply_qualified, select: select_fire, wdkey: wdkey_fire,
                wdt_normal: wdt_normal, wdt_sleep: wdt_sleep};
  wire any_full = ev.pin | ev.supply | ev.select | ev.wdkey | ev.wdt_normal;
  wire [2:0] set_cause = {ev.supply, ev.select, ev.wdkey};
  wire [7:0] wr_byte = wb_dat_i[7:0];
  wire [7:0] rd_thr = threshold_code;
  wire [7:0] rd_cause = {5'h00, cause};
  wire [7:0] rd_ctrl = {irq_mask, watchdog_enable_key};
  wire [7:0] rd_stat = {4'h0, state == rsc_pkg::RSC_RUN, sleep_idle_mode, watchdog_expiry_flag, powerdown_flag};
  wire [7:0] rd_byte = sel_thr ? rd_thr : sel_cause ? rd_cause : sel_ctrl ? rd_ctrl : sel_stat ? rd_stat : 8'h00;
  // Software write of zero clears; a hardware set in the same cycle wins.
  wire [2:0] next_cause = (bus_wr & sel_cause) ? ((cause & wr_byte[2:0]) | set_cause)
                                               : (cause | set_cause);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? {24'h0, rd_byte} : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers and flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      threshold_code <= `RSC_THR_POR;
      watchdog_enable_key <= `RSC_WDK_POR;
      cause <= 3'h0;
      irq_mask <= 3'h0;
    end else begin
      cause <= next_cause;
      if (ev.select) begin
        threshold_code <= `RSC_THR_POR;
      end else if (bus_wr & sel_thr) begin
        threshold_code <= wr_byte;
      end
      if (ev.wdkey) begin
        watchdog_enable_key <= `RSC_WDK_POR;
      end else if (bus_wr & sel_ctrl) begin
        watchdog_enable_key <= wr_byte[4:0];
        irq_mask <= wr_byte[7:5];
      end
    end
  end

  // ----------------------------------------------------------------
  // Qualification and fault delays
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      qual_cnt <= '0;
      fault_cnt <= '0;
      fault_select <= 1'b0;
      fault_wdkey <= 1'b0;
    end else begin
      // Short dips restart the count and never reach the limit.
      if (!sup_low) begin
        qual_cnt <= '0;
      end else if (qual_cnt != QW'(QUALIFY_CYC)) begin
        qual_cnt <= qual_cnt + QW'(1);
      end
      fault_select <= ~thr_valid & ~select_fire;
      fault_wdkey <= ~key_valid & ~wdkey_fire;
      if ((thr_valid & key_valid) | select_fire | wdkey_fire) begin
        fault_cnt <= '0;
      end else begin
        fault_cnt <= fault_cnt + FW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= rsc_pkg::RSC_START;
      start_cnt <= '0;
      core_full_rst <= 1'b1;
      core_pc_sp_rst <= 1'b1;
      por_defaults <= 1'b1;
      watchdog_enable <= 1'b1;
      watchdog_clear <= 1'b1;
      watchdog_expiry_flag <= 1'b0;
      powerdown_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq <= |(next_cause & irq_mask);
      watchdog_enable <= watchdog_enable_key != `RSC_WDK_DISABLE;
      core_pc_sp_rst <= any_full | ev.wdt_sleep | (state != rsc_pkg::RSC_RUN);
      core_full_rst <= any_full | (state != rsc_pkg::RSC_RUN);
      watchdog_clear <= any_full | (state != rsc_pkg::RSC_RUN) | (por_defaults & state == rsc_pkg::RSC_START);
      if (ev.wdt_normal | ev.wdt_sleep) begin
        watchdog_expiry_flag <= 1'b1;
      end
      if (ev.wdt_sleep) begin
        powerdown_flag <= 1'b1;
      end
      unique case (state)
        rsc_pkg::RSC_RUN: begin
          if (any_full) begin
            state <= rsc_pkg::RSC_HOLD;
          end
        end
        rsc_pkg::RSC_HOLD: begin
          start_cnt <= '0;
          if (!pin_low && !sup_low) begin
            state <= rsc_pkg::RSC_START;
          end
        end
        rsc_pkg::RSC_START: begin
          // Release waits out the start-up delay; a new cause restarts it.
          if (any_full) begin
            state <= rsc_pkg::RSC_HOLD;
          end else if (start_cnt == SW'(STARTUP_CYC)) begin
            state <= rsc_pkg::RSC_RUN;
            por_defaults <= 1'b0;
          end else begin
            start_cnt <= start_cnt + SW'(1);
          end
        end
      endcase
    end
  end
endmodule // rsc_reset_source_control

// File: rsc_reset_source_control_checker.sv
// Assertions on the reset source control ports.
`timescale 1ns/1ns
module rsc_reset_source_control_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Reset causes and outputs
  input wire logic external_rst_pin_n,
  input wire logic core_full_rst,
  input wire logic core_pc_sp_rst,
  input wire logic watchdog_clear,
  input wire logic watchdog_expiry_flag,
  input wire logic powerdown_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  chk_pin_full_rst: assert property ($fell(external_rst_pin_n) |-> ##[1:6] core_full_rst)
    else $error("pin reset missed");
  chk_full_with_pcsp: assert property (core_full_rst |-> core_pc_sp_rst)
    else $error("full reset without pc clear");
  chk_pcsp_pulse: assert property (core_pc_sp_rst && !core_full_rst |=> !core_pc_sp_rst)
    else $error("pc clear too long");
  chk_full_clears_wd: assert property (core_full_rst |-> watchdog_clear)
    else $error("watchdog not cleared");
  chk_pd_with_expiry: assert property ($rose(powerdown_flag) |-> watchdog_expiry_flag)
    else $error("powerdown flag alone");
  chk_flags_hold_pin: assert property (!external_rst_pin_n |=> $stable(watchdog_expiry_flag))
    else $error("flag changed on pin reset");
endmodule // rsc_reset_source_control_checker
bind rsc_reset_source_control rsc_reset_source_control_checker u_chk (
  .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .external_rst_pin_n(external_rst_pin_n), .core_full_rst(core_full_rst), .core_pc_sp_rst(core_pc_sp_rst),
  .watchdog_clear(watchdog_clear), .watchdog_expiry_flag(watchdog_expiry_flag),
  .powerdown_flag(powerdown_flag));

// File: tb_reset_source_control.sv
// Self-checking testbench for the reset source control block.
`timescale 1ns/1ns
`include "rsc_params.svh"
module tb_reset_source_control;
  logic core_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, pin_n = 1, sup = 0, pd = 0, slp = 0, wdto = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, full, pcsp, por, wd_en, wd_clr, exp_f, pd_f, irq, seen = 0;
  int error_cnt = 0, total_checks = 0;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (full) seen <= 1'b1;
  // Short counts keep every reset sequence within a few dozen cycles.
  rsc_reset_source_control #(.QUALIFY_CYC(8), .FAULT_CYC(6), .STARTUP_CYC(10)) uut (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .external_rst_pin_n(pin_n),
    .low_supply_monitor(sup), .powerdown_mode(pd), .sleep_idle_mode(slp), .watchdog_timeout(wdto),
    .core_full_rst(full), .core_pc_sp_rst(pcsp), .por_defaults(por), .watchdog_enable(wd_en),
    .watchdog_clear(wd_clr), .watchdog_expiry_flag(exp_f), .powerdown_flag(pd_f), .irq(irq));
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
      error_cnt++;
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk(ack, 1'b1);
    if (ack !== 1'b1) results();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h0);
    chk(q, e);
  endtask
  task automatic wait_rst(input logic [1:0] v, input int n);
    repeat (n) if ({full, pcsp} !== v) @(posedge core_clk);
    chk({full, pcsp}, v);
    if ({full, pcsp} !== v) results();
  endtask
  task automatic t_por;
    chk(por, 1'b1);
    rd(`RSC_OFS_THRESH, 32'h55);
    rd(`RSC_OFS_CAUSE, 32'h0);
    rd(4'h2, 32'h0);
    wait_rst(2'b00, 40);
    chk(por, 1'b0);
    seen <= 1'b0;
    $display("por done");
  endtask
  task automatic t_regs;
    logic [7:0] c[4] = '{`RSC_THR_2V10, `RSC_THR_2V55, `RSC_THR_3V15, `RSC_THR_3V80};
    foreach (c[i]) begin
      wb(1'b1, `RSC_OFS_THRESH, c[i]);
      rd(`RSC_OFS_THRESH, {24'h0, c[i]});
    end
    chk(seen, 1'b0);
    wb(1'b1, `RSC_OFS_THRESH, 8'h12);
    wait_rst(2'b11, 30);
    wait_rst(2'b00, 40);
    rd(`RSC_OFS_THRESH, 32'h55);
    wb(1'b1, `RSC_OFS_CAUSE, 8'hff);
    rd(`RSC_OFS_CAUSE, 32'h2);
    wb(1'b1, `RSC_OFS_CTRL, 8'h4a);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b1);
    wb(1'b1, `RSC_OFS_CTRL, 8'h0a);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0);
    wb(1'b1, `RSC_OFS_CTRL, 8'h4a);
    wb(1'b1, `RSC_OFS_CAUSE, 8'h05);
    rd(`RSC_OFS_CAUSE, 32'h0);
    chk(irq, 1'b0);
    $display("regs done");
  endtask
  task automatic t_supply;
    wb(1'b1, `RSC_OFS_THRESH, `RSC_THR_3V15);
    seen <= 1'b0;
    sup <= 1'b1;
    repeat (4) @(posedge core_clk);
    sup <= 1'b0;
    repeat (30) @(posedge core_clk);
    chk(seen, 1'b0);
    sup <= 1'b1;
    wait_rst(2'b11, 30);
    sup <= 1'b0;
    wait_rst(2'b00, 40);
    rd(`RSC_OFS_CAUSE, 32'h4);
    rd(`RSC_OFS_THRESH, 32'h99);
    pd <= 1'b1;
    seen <= 1'b0;
    sup <= 1'b1;
    repeat (30) @(posedge core_clk);
    sup <= 1'b0;
    repeat (5) @(posedge core_clk);
    pd <= 1'b0;
    chk(seen, 1'b0);
    $display("supply done");
  endtask
  task automatic t_wdt;
    pin_n <= 1'b0;
    wait_rst(2'b11, 10);
    pin_n <= 1'b1;
    wait_rst(2'b00, 40);
    rd(`RSC_OFS_STATUS, 32'h8);
    wdto <= 1'b1;
    @(posedge core_clk);
    wdto <= 1'b0;
    wait_rst(2'b11, 10);
    wait_rst(2'b00, 40);
    rd(`RSC_OFS_STATUS, 32'ha);
    slp <= 1'b1;
    seen <= 1'b0;
    wdto <= 1'b1;
    @(posedge core_clk);
    wdto <= 1'b0;
    wait_rst(2'b01, 10);
    repeat (5) @(posedge core_clk);
    chk(seen, 1'b0);
    rd(`RSC_OFS_STATUS, 32'hf);
    slp <= 1'b0;
    wb(1'b1, `RSC_OFS_CTRL, 8'h03);
    wait_rst(2'b11, 30);
    wait_rst(2'b00, 40);
    rd(`RSC_OFS_CAUSE, 32'h5);
    wb(1'b1, `RSC_OFS_CTRL, {3'h0, `RSC_WDK_DISABLE});
    repeat (2) @(posedge core_clk);
    chk(wd_en, 1'b0);
    $display("wdt done");
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_por();
    t_regs();
    t_supply();
    t_wdt();
    results();
  end
endmodule // tb_reset_source_control
